// ===== logic/mnd_decode.v
// decode and execute for copy-file, store-working and no-operation
// assumes the register file answers a read in the same cycle (comb read
// data on file_rdata for file_raddr) and takes one write per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "mnd_defs.vh"

module mnd_decode (
  input wire clk,
  input wire rst_b,
  input wire instr_valid,
  input wire [13:0] instr,
  input wire [7:0] file_rdata,
  output wire [6:0] file_raddr,
  output reg file_we_q,
  output reg [6:0] file_waddr_q,
  output reg [7:0] file_wdata_q,
  output reg [7:0] working_q,
  output reg zero_flag_q,
  output reg zero_we_q,
  output reg illegal_q
);

  // ************************************************************
  // op classes
  // ************************************************************
  // one-hot class of the word seen this cycle
  localparam [4:0] OP_IDLE = 5'h01;
  localparam [4:0] OP_COPY = 5'h02;
  localparam [4:0] OP_STORE = 5'h04;
  localparam [4:0] OP_NOP = 5'h08;
  localparam [4:0] OP_OTHER = 5'h10;

  // ************************************************************
  // decode
  // ************************************************************
  wire copy_file_instr;
  wire store_working_instr;
  wire no_operation_instr;
  wire dest_file;
  wire [6:0] addr;
  wire [7:0] any_one;
  wire moved_is_zero;
  reg [4:0] op_class;
  reg file_we_d;
  reg [6:0] file_waddr_d;
  reg [7:0] file_wdata_d;
  reg [7:0] working_d;
  reg zero_flag_d;
  reg zero_we_d;
  reg illegal_d;

  assign copy_file_instr = instr_valid &&
    ((instr & `MND_COPY_MASK) == `MND_COPY_MATCH);
  assign store_working_instr = instr_valid &&
    ((instr & `MND_STORE_MASK) == `MND_STORE_MATCH);
  // bits 6:5 ignored so all four don't-care forms decode
  assign no_operation_instr = instr_valid &&
    ((instr & `MND_NOP_MASK) == `MND_NOP_MATCH);
  assign dest_file = instr[`MND_DEST_BIT];
  assign addr = instr[`MND_ADDR_MSB:0];

  // read port is combinational so the copy completes in one cycle;
  // the only output not taken from a flop, a register would cost a cycle
  assign file_raddr = addr;

  always @* begin
    op_class = OP_IDLE;
    if (!instr_valid) begin
      op_class = OP_IDLE;
    end else if (copy_file_instr) begin
      op_class = OP_COPY;
    end else if (store_working_instr) begin
      op_class = OP_STORE;
    end else if (no_operation_instr) begin
      op_class = OP_NOP;
    end else begin
      // other opcodes belong to other decode slices
      op_class = OP_OTHER;
    end
  end

  // ************************************************************
  // zero detect
  // ************************************************************
  // or chain over the moved value, one stage per data bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_zero
      if (gi == 0) begin : g_first
        assign any_one[gi] = file_rdata[gi];
      end else begin : g_rest
        assign any_one[gi] = any_one[gi-1] | file_rdata[gi];
      end
    end
  endgenerate
  assign moved_is_zero = ~any_one[7];

  // ************************************************************
  // next values
  // ************************************************************
  // strobes default low, data registers hold
  always @* begin
    file_we_d = 1'b0;
    file_waddr_d = file_waddr_q;
    file_wdata_d = file_wdata_q;
    working_d = working_q;
    zero_flag_d = zero_flag_q;
    zero_we_d = 1'b0;
    illegal_d = 1'b0;
    case (op_class)
      OP_COPY: begin
        if (dest_file) begin
          // write back to itself: useful as a zero test
          file_we_d = 1'b1;
          file_waddr_d = addr;
          file_wdata_d = file_rdata;
        end else begin
          working_d = file_rdata;
        end
        zero_flag_d = moved_is_zero;
        zero_we_d = 1'b1;
      end
      OP_STORE: begin
        // flags left alone on purpose
        file_we_d = 1'b1;
        file_waddr_d = addr;
        file_wdata_d = working_q;
      end
      OP_NOP: begin
        file_we_d = 1'b0;
      end
      OP_OTHER: begin
        // flagged only; no state changes for unknown words
        illegal_d = 1'b1;
      end
      default: begin
        file_we_d = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  // write strobe, one cycle per write
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      file_we_q <= 1'b0;
    end else begin
      file_we_q <= file_we_d;
    end
  end

  // write address holds between writes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      file_waddr_q <= 7'h00;
    end else begin
      file_waddr_q <= file_waddr_d;
    end
  end

  // write data holds between writes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      file_wdata_q <= 8'h00;
    end else begin
      file_wdata_q <= file_wdata_d;
    end
  end

  // working register
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      working_q <= `MND_W_RESET;
    end else begin
      working_q <= working_d;
    end
  end

  // zero flag value; the status register owner merges it on zero_we_q
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      zero_flag_q <= `MND_Z_RESET;
    end else begin
      zero_flag_q <= zero_flag_d;
    end
  end

  // zero flag update strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      zero_we_q <= 1'b0;
    end else begin
      zero_we_q <= zero_we_d;
    end
  end

  // unknown word strobe, one cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= illegal_d;
    end
  end

endmodule
`default_nettype wire

// ===== logic/mnd_defs.vh
// constants for the copy / store / no-operation decode and execute block
// assumes 14-bit instruction words and 7-bit file addresses
`ifndef MND_DEFS_VH
`define MND_DEFS_VH

// ************************************************************
// encodings
// ************************************************************
`define MND_COPY_MASK 14'h3F00
`define MND_COPY_MATCH 14'h0800
`define MND_STORE_MASK 14'h3F80
`define MND_STORE_MATCH 14'h0080
`define MND_NOP_MASK 14'h3F9F
`define MND_NOP_MATCH 14'h0000

// ************************************************************
// field positions
// ************************************************************
`define MND_DEST_BIT 7
`define MND_ADDR_MSB 6

// ************************************************************
// reset values
// ************************************************************
`define MND_W_RESET 8'h00
`define MND_Z_RESET 1'b0

`endif

// ===== verification/mnd_chk.sv
// checker for mnd_decode ports; one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module mnd_chk (
  input wire clk,
  input wire rst_b,
  input wire instr_valid,
  input wire [13:0] instr,
  input wire [7:0] file_rdata,
  input wire [6:0] file_raddr,
  input wire file_we_q,
  input wire [6:0] file_waddr_q,
  input wire [7:0] file_wdata_q,
  input wire [7:0] working_q,
  input wire zero_flag_q,
  input wire zero_we_q,
  input wire illegal_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire cp = instr_valid && instr[13:8] == 6'h08;
  wire st = instr_valid && instr[13:7] == 7'h01;
  wire np = instr_valid && (instr & 14'h3F9F) == 14'h0000;
  copy_work_a: assert property (
    cp && !instr[7] |=> !file_we_q && working_q == $past(file_rdata))
    else $error("copy to working");
  copy_back_a: assert property (
    cp && instr[7] |=> file_we_q && file_wdata_q == $past(file_rdata))
    else $error("copy back");
  zero_upd_a: assert property (
    cp |=> zero_flag_q == ($past(file_rdata) == 8'h00)) else $error("zero");
  store_w_a: assert property (
    st |=> file_we_q && $stable(zero_flag_q) &&
    file_wdata_q == $past(working_q)) else $error("store");
  nop_idle_a: assert property (
    np |=> !file_we_q && $stable(working_q) && $stable(zero_flag_q))
    else $error("no-op changed state");
  read_addr_a: assert property (
    cp |-> file_raddr == instr[6:0]) else $error("read address");
  copy_waddr_a: assert property (
    cp && instr[7] |=> file_waddr_q == $past(instr[6:0]))
    else $error("copy back address");
  zero_strobe_a: assert property (
    cp |=> zero_we_q) else $error("zero strobe");
  store_addr_a: assert property (
    st |=> file_waddr_q == $past(instr[6:0]) && !zero_we_q)
    else $error("store address");
  nop_quiet_a: assert property (
    np |=> !zero_we_q && !illegal_q) else $error("no-op strobes");
endmodule
bind mnd_decode mnd_chk chk_u (
  .clk(clk),
  .rst_b(rst_b),
  .instr_valid(instr_valid),
  .instr(instr),
  .file_rdata(file_rdata),
  .file_raddr(file_raddr),
  .file_we_q(file_we_q),
  .file_waddr_q(file_waddr_q),
  .file_wdata_q(file_wdata_q),
  .working_q(working_q),
  .zero_flag_q(zero_flag_q),
  .zero_we_q(zero_we_q),
  .illegal_q(illegal_q)
);
`default_nettype wire

// ===== verification/test_mnd_decode.sv
// bench for mnd_decode; drives the read data in the file's place
`timescale 1ns/1ps
`default_nettype none
module test_mnd_decode;
  logic clk = 0, rst_b = 0, instr_valid = 0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] file_rdata = 8'h00;
  wire [6:0] file_raddr, file_waddr_q;
  wire [7:0] file_wdata_q, working_q;
  wire file_we_q, zero_flag_q, zero_we_q, illegal_q;
  // word, read data, then expected we, write data, working, zero
  logic [39:0] r [6] = '{{14'h0810, 8'h5A, 18'h000B4},
    {14'h00A5, 8'h33, 18'h2B4B4}, {14'h0890, 8'h00, 18'h200B5},
    {14'h0020, 8'hFF, 18'h000B5}, {14'h0040, 8'h00, 18'h000B5},
    {14'h0060, 8'h00, 18'h000B5}};
  int error_cnt = 0, tests_run = 0;
  always #25 clk = ~clk;
  mnd_decode dut_u (
    .clk(clk),
    .rst_b(rst_b),
    .instr_valid(instr_valid),
    .instr(instr),
    .file_rdata(file_rdata),
    .file_raddr(file_raddr),
    .file_we_q(file_we_q),
    .file_waddr_q(file_waddr_q),
    .file_wdata_q(file_wdata_q),
    .working_q(working_q),
    .zero_flag_q(zero_flag_q),
    .zero_we_q(zero_we_q),
    .illegal_q(illegal_q)
  );
  // one word presented for one edge, then checked 1 ns after that same edge
  task step(input logic [13:0] w, input logic [7:0] d);
    @(posedge clk);
    instr_valid <= 1'b1;
    {instr, file_rdata} <= {w, d};
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task chk(string n, logic [26:0] e, logic [26:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    $display("%0d checks, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1;
    for (int i = 0; i <= 6; i++) begin
      @(posedge clk);
      instr_valid <= i < 6;
      if (i < 6) {instr, file_rdata} <= r[i][39:18];
      #1 if (i > 0) chk("state", r[i-1][17:0], {file_we_q, file_wdata_q,
        working_q, zero_flag_q});
    end
    $display("row tests done");
    step(14'h00FF, 8'h00);
    chk("store", {1'b1, 7'h7F, 8'h5A, 8'h5A, 3'b100}, {file_we_q,
      file_waddr_q, file_wdata_q, working_q, zero_flag_q, zero_we_q,
      illegal_q});
    step(14'h0010, 8'hFF);
    chk("other", {1'b0, 7'h7F, 8'h5A, 8'h5A, 3'b101}, {file_we_q,
      file_waddr_q, file_wdata_q, working_q, zero_flag_q, zero_we_q,
      illegal_q});
    step(14'h0801, 8'h80);
    chk("copy", {1'b0, 7'h7F, 8'h5A, 8'h80, 3'b010}, {file_we_q,
      file_waddr_q, file_wdata_q, working_q, zero_flag_q, zero_we_q,
      illegal_q});
    step(14'h0060, 8'h00);
    chk("nop", {1'b0, 7'h7F, 8'h5A, 8'h80, 3'b000}, {file_we_q,
      file_waddr_q, file_wdata_q, working_q, zero_flag_q, zero_we_q,
      illegal_q});
    $display("hand tests done");
    @(posedge clk) rst_b <= 0;
    #1 chk("reset", 0, {file_we_q, file_waddr_q, file_wdata_q, working_q,
      zero_flag_q, zero_we_q, illegal_q});
    @(posedge clk) rst_b <= 1;
    step(14'h08FF, 8'h3C);
    chk("after", {1'b1, 7'h7F, 8'h3C, 8'h00, 3'b010}, {file_we_q,
      file_waddr_q, file_wdata_q, working_q, zero_flag_q, zero_we_q,
      illegal_q});
    $display("reset test done");
    test_done;
  end
endmodule
`default_nettype wire
